// >>> pkg/fcs_host_regs.vh
`ifndef FCS_HOST_REGS_VH
`define FCS_HOST_REGS_VH
// Operation
// - During erase writes output enable stays high while write strobe and chip enable are low.
// - Whole-chip erase uses 10H in the final write of the erase sequence.
// - Main-block erase uses data 30H in the final write of the erase sequence.
// - While an internal operation runs, status is polled by toggling output enable.
// - Polling reads keep one address throughout.

// Clock
`define FCS_CLK_MHZ        25

// Timing in ns, and derived cycle counts (minimums round up)
`define FCS_T_WP_NS        50
`define FCS_T_WPH_NS       40
`define FCS_T_AH_NS        50
`define FCS_T_ACC_NS       70
`define FCS_T_OEHP_NS      150
`define FCS_WP_CYC   ((`FCS_T_WP_NS   * `FCS_CLK_MHZ + 999) / 1000)
`define FCS_WPH_CYC  ((`FCS_T_WPH_NS  * `FCS_CLK_MHZ + 999) / 1000)
`define FCS_AH_CYC   ((`FCS_T_AH_NS   * `FCS_CLK_MHZ + 999) / 1000)
`define FCS_ACC_CYC  ((`FCS_T_ACC_NS  * `FCS_CLK_MHZ + 999) / 1000)
`define FCS_OEHP_CYC ((`FCS_T_OEHP_NS * `FCS_CLK_MHZ + 999) / 1000)
// Longest erase time in seconds; cycles round down
`define FCS_T_EC_S         3
`define FCS_EC_CYC   (`FCS_T_EC_S * `FCS_CLK_MHZ * 1000000)
// Input synchroniser depth added to every read sample point
`define FCS_SYNC_CYC       2

// User operations
`define FCS_OP_READ        3'h0
`define FCS_OP_CHIP_ERASE  3'h1
`define FCS_OP_MAIN_ERASE  3'h2
`define FCS_OP_ID_ENTRY    3'h3
`define FCS_OP_ID_EXIT     3'h4
`define FCS_OP_LOCKOUT     3'h5
`define FCS_OP_ID_READ     3'h6

// Command sequence addresses and data bytes
`define FCS_ADDR_A         15'h5555
`define FCS_ADDR_B         15'h2aaa
`define FCS_ADDR_CHIP      15'h0010
`define FCS_DAT_UNLOCK1    8'haa
`define FCS_DAT_UNLOCK2    8'h55
`define FCS_DAT_ERASE      8'h80
`define FCS_DAT_CHIP       8'h10
`define FCS_DAT_MAIN       8'h30
`define FCS_DAT_ID_ENTRY   8'h90
`define FCS_DAT_ID_EXIT    8'hf0
`define FCS_DAT_LOCKOUT    8'h40

// Toggle status bit position
`define FCS_TOGGLE_BIT     6
`endif

// >>> rtl/fcs_seq_table.v
`include "fcs_host_regs.vh"
module fcs_seq_table (
  input  wire [2:0]  op,
  input  wire [2:0]  step,
  output reg  [14:0] cmdAddr,
  output reg  [7:0]  cmdByte,
  output reg         lastStep,
  output reg         hasWrites,
  output reg         needPoll
);
  ////////////////////////////////////////////////////////////////////////////
  always @* begin
    hasWrites = 1'b1;
    needPoll  = 1'b0;
    cmdAddr   = `FCS_ADDR_A;
    cmdByte   = `FCS_DAT_UNLOCK1;
    lastStep  = 1'b0;
    // Shared two-write unlock prefix
    if (step[0] == 1'b1 && step != 3'h3) begin
      cmdAddr = `FCS_ADDR_B;
      cmdByte = `FCS_DAT_UNLOCK2;
    end
    case (op)
      `FCS_OP_CHIP_ERASE, `FCS_OP_MAIN_ERASE, `FCS_OP_LOCKOUT: begin
        needPoll = 1'b1;
        if (step == 3'h2) begin
          cmdByte = `FCS_DAT_ERASE;
        end else if (step == 3'h3) begin
          cmdAddr = `FCS_ADDR_A;
          cmdByte = `FCS_DAT_UNLOCK1;
        end else if (step == 3'h4) begin
          cmdAddr = `FCS_ADDR_B;
          cmdByte = `FCS_DAT_UNLOCK2;
        end else if (step == 3'h5) begin
          lastStep = 1'b1;
          // Odd step would otherwise pick the second unlock address
          cmdAddr  = `FCS_ADDR_A;
          if (op == `FCS_OP_CHIP_ERASE) begin
            // Both address and data carry 10H so either reading selects chip erase
            cmdAddr = `FCS_ADDR_CHIP;
            cmdByte = `FCS_DAT_CHIP;
          end else if (op == `FCS_OP_MAIN_ERASE) begin
            cmdByte = `FCS_DAT_MAIN;
          end else begin
            cmdByte = `FCS_DAT_LOCKOUT;
          end
        end
      end
      `FCS_OP_ID_ENTRY, `FCS_OP_ID_EXIT: begin
        if (step == 3'h2) begin
          lastStep = 1'b1;
          cmdByte  = (op == `FCS_OP_ID_EXIT) ? `FCS_DAT_ID_EXIT : `FCS_DAT_ID_ENTRY;
        end
      end
      default: begin
        hasWrites = 1'b0;
        lastStep  = 1'b1;
      end
    endcase
  end
endmodule

// >>> rtl/fcs_host_ctrl.v
`include "fcs_host_regs.vh"
module fcs_host_ctrl #(
  parameter [26:0] EC_CYC = `FCS_EC_CYC
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        cmdValid,
  input  wire [2:0]  cmdOp,
  input  wire [15:0] cmdAddr,
  output wire        cmdReady,
  output reg         respValid_q,
  output reg  [15:0] respData_q,
  output reg         respTimeout_q,
  output reg  [15:0] flashAddr_q,
  output reg  [15:0] flashDqOut_q,
  output reg         flashDqOe_q,
  input  wire [15:0] flashDqIn,
  output reg         flashCeB_q,
  output reg         flashOeB_q,
  output reg         flashWeB_q
);
  ////////////////////////////////////////////////////////////////////////////
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_WSET  = 3'h1;
  localparam [2:0] ST_WLOW  = 3'h2;
  localparam [2:0] ST_WHIGH = 3'h3;
  localparam [2:0] ST_RLOW  = 3'h4;
  localparam [2:0] ST_RHIGH = 3'h5;
  localparam [2:0] ST_DONE  = 3'h6;

  localparam integer WP_INT   = `FCS_WP_CYC;
  localparam integer WH_INT   = (`FCS_WPH_CYC > `FCS_AH_CYC) ? `FCS_WPH_CYC : `FCS_AH_CYC;
  localparam integer RD_INT   = `FCS_ACC_CYC + `FCS_SYNC_CYC;
  localparam integer OEHP_INT = `FCS_OEHP_CYC;
  // Counts are small; cut to the 8-bit cycle counter on purpose
  localparam [7:0]   WP_CYC   = WP_INT[7:0];
  localparam [7:0]   WH_CYC   = WH_INT[7:0];
  localparam [7:0]   RD_CYC   = RD_INT[7:0];
  localparam [7:0]   OEHP_CYC = OEHP_INT[7:0];

  reg  [2:0]  state_q;
  reg  [2:0]  op_q;
  reg  [2:0]  step_q;
  reg  [15:0] addr_q;
  reg  [7:0]  cnt_q;
  reg  [26:0] waitCnt_q;
  reg         prevToggle_q;
  reg         havePrev_q;
  reg  [15:0] dqMeta_q;
  reg  [15:0] dqSync_q;

  wire [14:0] seqAddr;
  wire [7:0]  seqByte;
  wire        seqLast;
  wire        seqWrites;
  wire        seqPoll;

  fcs_seq_table fcs_seq_table_i (
    .op        (op_q),
    .step      (step_q),
    .cmdAddr   (seqAddr),
    .cmdByte   (seqByte),
    .lastStep  (seqLast),
    .hasWrites (seqWrites),
    .needPoll  (seqPoll)
  );

  assign cmdReady = (state_q == ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Data pins come from another timing domain; two flops before any use
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dqMeta_q <= 16'h0000;
      dqSync_q <= 16'h0000;
    end else begin
      dqMeta_q <= flashDqIn;
      dqSync_q <= dqMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q       <= ST_IDLE;
      op_q          <= `FCS_OP_READ;
      step_q        <= 3'h0;
      addr_q        <= 16'h0000;
      cnt_q         <= 8'h00;
      waitCnt_q     <= 27'h0000000;
      prevToggle_q  <= 1'b0;
      havePrev_q    <= 1'b0;
      respValid_q   <= 1'b0;
      respData_q    <= 16'h0000;
      respTimeout_q <= 1'b0;
      flashAddr_q   <= 16'h0000;
      flashDqOut_q  <= 16'h0000;
      flashDqOe_q   <= 1'b0;
      flashCeB_q    <= 1'b1;
      flashOeB_q    <= 1'b1;
      flashWeB_q    <= 1'b1;
    end else begin
      respValid_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          flashCeB_q  <= 1'b1;
          flashOeB_q  <= 1'b1;
          flashWeB_q  <= 1'b1;
          flashDqOe_q <= 1'b0;
          if (cmdValid) begin
            op_q       <= cmdOp;
            step_q     <= 3'h0;
            havePrev_q <= 1'b0;
            waitCnt_q  <= 27'h0000000;
            // Identification read: lines 1 to 15 low, bit 0 picks the code
            if (cmdOp == `FCS_OP_ID_READ) begin
              addr_q <= {15'h0000, cmdAddr[0]};
            end else begin
              addr_q <= cmdAddr;
            end
            state_q <= ST_WSET;
          end
        end
        ST_WSET: begin
          cnt_q <= 8'h00;
          if (seqWrites) begin
            // Top line is don't-care to the device; drive it low for a clean bus
            flashAddr_q  <= {1'b0, seqAddr};
            flashDqOut_q <= {8'h00, seqByte};
            flashDqOe_q  <= 1'b1;
            flashCeB_q   <= 1'b0;
            flashOeB_q   <= 1'b1;
            flashWeB_q   <= 1'b1;
            state_q      <= ST_WLOW;
          end else begin
            flashAddr_q <= addr_q;
            flashDqOe_q <= 1'b0;
            flashCeB_q  <= 1'b0;
            flashOeB_q  <= 1'b0;
            state_q     <= ST_RLOW;
          end
        end
        ST_WLOW: begin
          // Output enable held high for the whole strobe so no write is inhibited
          flashOeB_q <= 1'b1;
          flashWeB_q <= 1'b0;
          cnt_q      <= cnt_q + 8'h01;
          // First cycle only lowers the strobe, so the low phase lasts WP_CYC
          if (cnt_q == WP_CYC) begin
            flashWeB_q <= 1'b1;
            cnt_q      <= 8'h00;
            state_q    <= ST_WHIGH;
          end
        end
        ST_WHIGH: begin
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q == WH_CYC - 8'h01) begin
            cnt_q       <= 8'h00;
            flashDqOe_q <= 1'b0;
            if (!seqLast) begin
              step_q  <= step_q + 3'h1;
              state_q <= ST_WSET;
            end else if (seqPoll) begin
              // Poll address fixed for the whole wait
              flashAddr_q <= addr_q;
              flashOeB_q  <= 1'b0;
              state_q     <= ST_RLOW;
            end else begin
              // Identification entry and exit have no busy phase to wait for
              flashCeB_q <= 1'b1;
              state_q    <= ST_DONE;
            end
          end
        end
        ST_RLOW: begin
          cnt_q     <= cnt_q + 8'h01;
          waitCnt_q <= waitCnt_q + 27'h0000001;
          if (cnt_q == RD_CYC - 8'h01) begin
            cnt_q      <= 8'h00;
            flashOeB_q <= 1'b1;
            if (!seqPoll) begin
              respData_q <= dqSync_q;
              flashCeB_q <= 1'b1;
              state_q    <= ST_DONE;
            end else begin
              // Only a repeat level means done; no fixed level is trusted
              prevToggle_q <= dqSync_q[`FCS_TOGGLE_BIT];
              havePrev_q   <= 1'b1;
              if (havePrev_q && prevToggle_q == dqSync_q[`FCS_TOGGLE_BIT]) begin
                respData_q <= dqSync_q;
                flashCeB_q <= 1'b1;
                state_q    <= ST_DONE;
              end else if (waitCnt_q >= EC_CYC) begin
                respTimeout_q <= 1'b1;
                flashCeB_q    <= 1'b1;
                state_q       <= ST_DONE;
              end else begin
                state_q <= ST_RHIGH;
              end
            end
          end
        end
        ST_RHIGH: begin
          // High phase of the toggle must last the minimum pulse width
          cnt_q     <= cnt_q + 8'h01;
          waitCnt_q <= waitCnt_q + 27'h0000001;
          if (cnt_q == OEHP_CYC - 8'h01) begin
            cnt_q      <= 8'h00;
            flashOeB_q <= 1'b0;
            state_q    <= ST_RLOW;
          end
        end
        ST_DONE: begin
          respValid_q <= 1'b1;
          state_q     <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      if (state_q == ST_IDLE && cmdValid) begin
        respTimeout_q <= 1'b0;
      end
    end
  end
  // Power-down drops identification mode in the device; the host keeps no mode
  // state of its own, so nothing here can disagree after a restart.
endmodule

// >>> dv/fcs_host_props.sv
module fcs_host_props (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        cmdValid,
  input wire logic [2:0]  cmdOp,
  input wire logic [15:0] cmdAddr,
  input wire logic        cmdReady,
  input wire logic        respValid_q,
  input wire logic [15:0] flashAddr_q,
  input wire logic [15:0] flashDqOut_q,
  input wire logic        flashDqOe_q,
  input wire logic        flashCeB_q,
  input wire logic        flashOeB_q,
  input wire logic        flashWeB_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // A repeat poll is an OE fall with no write or deselect since the last one
  logic        sawRead_q;
  logic [15:0] pollAddr_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sawRead_q  <= 1'b0;
      pollAddr_q <= 16'h0000;
    end else if (!flashWeB_q || flashCeB_q) begin
      sawRead_q <= 1'b0;
    end else if (!flashOeB_q) begin
      sawRead_q  <= 1'b1;
      pollAddr_q <= flashAddr_q;
    end
  end
  oe_in_write_a: assert property (!flashWeB_q |-> flashOeB_q && !flashCeB_q)
    else $error("OE low or CE high in a write pulse");
  upper_byte_a: assert property (flashDqOe_q |-> flashDqOut_q[15:8] == 8'h00)
    else $error("upper data byte not zero in a write");
  top_line_a: assert property (!flashWeB_q |-> !flashAddr_q[15])
    else $error("top address line high in a write");
  poll_addr_a: assert property ($fell(flashOeB_q) && sawRead_q |-> flashAddr_q == pollAddr_q)
    else $error("address moved between polls");
  poll_gap_a: assert property ($fell(flashOeB_q) && sawRead_q |->
    $past(flashOeB_q, 2) && $past(flashOeB_q, 3) && $past(flashOeB_q, 4))
    else $error("OE high gap between polls too short");
  write_pulse_a: assert property ($fell(flashWeB_q) |=> !flashWeB_q ##1 flashWeB_q [*2])
    else $error("write pulse shape wrong");
  write_data_a: assert property (!flashWeB_q |-> $stable(flashDqOut_q) && flashDqOe_q)
    else $error("write data not held in pulse");
  read_walk_a: assert property (cmdValid && cmdReady && cmdOp == 3'h0 |-> ##2
    (flashAddr_q == $past(cmdAddr, 2) && !flashOeB_q) ##5 respValid_q)
    else $error("read walk wrong");
  resp_pulse_a: assert property (respValid_q |=> !respValid_q && cmdReady)
    else $error("answer pulse not one cycle");
  read_done_c: cover property (cmdValid && cmdReady && cmdOp == 3'h0 ##7 respValid_q);
  repeat_poll_c: cover property ($fell(flashOeB_q) && sawRead_q);
  write_seen_c: cover property ($fell(flashWeB_q));
endmodule
bind fcs_host_ctrl fcs_host_props fcs_host_props_i (
  .clk, .rst_b, .cmdValid, .cmdOp, .cmdAddr, .cmdReady, .respValid_q, .flashAddr_q,
  .flashDqOut_q, .flashDqOe_q, .flashCeB_q, .flashOeB_q, .flashWeB_q
);

// >>> dv/fcs_flash_model.sv
module fcs_flash_model #(
  parameter logic [15:0] MAKER_CODE = 16'h0a0a, // Arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h0b0b  // Arbitrary value
) (
  input  wire logic        pwrUp,
  input  wire logic [15:0] busyLen,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] dqIn,
  input  wire logic        ceB,
  input  wire logic        oeB,
  input  wire logic        weB,
  output wire logic        drv,
  output wire logic [15:0] dqOut
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [22:0] U1 = {15'h5555, 8'haa};
  localparam logic [22:0] U2 = {15'h2aaa, 8'h55};
  logic [22:0] hist [0:5];
  logic        idMode = 1'b0;
  logic        locked = 1'b0;
  logic        tog = 1'b0;
  logic [1:0]  lastKind = 2'h0;
  int          polls = 0;
  int          busyEnd = 0;
  wire         busy = polls < busyEnd;
  wire  [15:0] arr = addr ^ 16'h3c5a;
  assign drv = pwrUp && !ceB && !oeB && weB;
  assign dqOut = busy ? {arr[15:7], tog, arr[5:0]} :
    (idMode && addr[15:1] == 15'h0000) ? (addr[0] ? PART_CODE : MAKER_CODE) : arr;
  // Either strobe falling starts a status read
  always @(negedge oeB or negedge ceB) begin
    if (!oeB && !ceB && busy) begin
      tog = !tog;
      polls++;
    end
  end
  always @(posedge weB or negedge pwrUp) begin
    if (!pwrUp) begin
      idMode = 1'b0;
      busyEnd = polls;
    end else if (!ceB) begin
      for (int i = 5; i > 0; i--) hist[i] = hist[i - 1];
      hist[0] = {addr[14:0], dqIn[7:0]};
      if (hist[2] == U1 && hist[1] == U2 && hist[0][22:8] == 15'h5555) begin
        if (hist[0][7:0] == 8'h90) idMode = 1'b1;
        if (hist[0][7:0] == 8'hf0) idMode = 1'b0;
      end
      if (hist[5] == U1 && hist[4] == U2 && hist[3] == {15'h5555, 8'h80} &&
          hist[2] == U1 && hist[1] == U2) begin
        if (hist[0][22:8] == 15'h0010) lastKind = 2'h1;
        if (hist[0] == {15'h5555, 8'h30}) lastKind = 2'h2;
        if (hist[0] == {15'h5555, 8'h40}) begin
          lastKind = 2'h3;
          locked = 1'b1;
        end else begin
          busyEnd = polls + busyLen;
        end
      end
    end
  end
endmodule

// >>> dv/tb_fcs_host_ctrl.sv
module tb_fcs_host_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] SCR = 16'h3c5a;
  localparam logic [15:0] MAKER = 16'h0c0c; // Arbitrary value
  localparam logic [15:0] PART = 16'h0d0d;  // Arbitrary value
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        pwrUp = 1'b1;
  logic        cmdValid = 1'b0;
  logic [2:0]  cmdOp = 3'h0;
  logic [15:0] cmdAddr = 16'h0000;
  logic [15:0] busyLen = 16'h0003;
  logic [15:0] lastDq = 16'h0000;
  logic [15:0] rd;
  logic        to;
  int          nErrors = 0;
  int          numChecks = 0;
  int          cyc = 0;
  wire         cmdReady, respValid_q, respTimeout_q, flashDqOe_q, mdlDrv;
  wire         flashCeB_q, flashOeB_q, flashWeB_q;
  wire  [15:0] respData_q, flashAddr_q, flashDqOut_q, mdlDq;
  // Nobody driving: show the inverse of the last level, never a stale copy
  wire  [15:0] flashDqIn = flashDqOe_q ? flashDqOut_q : mdlDrv ? mdlDq : ~lastDq;
  fcs_host_ctrl #(.EC_CYC(27'd200)) fcs_host_ctrl_i (.clk, .rst_b, .cmdValid, .cmdOp,
    .cmdAddr, .cmdReady, .respValid_q, .respData_q, .respTimeout_q, .flashAddr_q,
    .flashDqOut_q, .flashDqOe_q, .flashDqIn, .flashCeB_q, .flashOeB_q, .flashWeB_q);
  fcs_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) fcs_flash_model_i (.pwrUp,
    .busyLen, .addr(flashAddr_q), .dqIn(flashDqOut_q), .ceB(flashCeB_q), .oeB(flashOeB_q),
    .weB(flashWeB_q), .drv(mdlDrv), .dqOut(mdlDq));
  always #20 clk = ~clk;
  task automatic endSim();
    if (nErrors == 0 && numChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (flashDqOe_q || mdlDrv) lastDq <= flashDqIn;
    if (cyc == 30000) begin
      nErrors++;
      $display("[ERR] %0t ns: run too long", $time);
      endSim();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic run(input logic [2:0] op, input logic [15:0] a);
    int n;
    cmdOp = op;
    cmdAddr = a;
    cmdValid = 1'b1;
    @(negedge clk);
    cmdValid = 1'b0;
    for (n = 0; n < 5000 && respValid_q !== 1'b1; n++) @(negedge clk);
    chk({15'h0, respValid_q}, 16'h0001);
    rd = respData_q;
    to = respTimeout_q;
    @(negedge clk);
  endtask
  task automatic pwrCycle();
    pwrUp = 1'b0;
    @(negedge clk);
    pwrUp = 1'b1;
  endtask
  ////////////////////////////////////////
  task automatic tIdent();
    run(3'h3, 16'h0000);
    run(3'h6, 16'h0000);
    chk(rd, MAKER);
    run(3'h6, 16'h0001);
    chk(rd, PART);
    run(3'h4, 16'h0000);
    run(3'h0, 16'h8001);
    chk(rd, 16'h8001 ^ SCR);
    run(3'h3, 16'h0000);
    pwrCycle();
    run(3'h6, 16'h0000);
    chk(rd, SCR);
  endtask
  task automatic tErase();
    logic [2:0] ops [3] = '{3'h1, 3'h2, 3'h5};
    for (int i = 0; i < 3; i++) begin
      busyLen = 16'(3 + 8 * i);
      run(ops[i], 16'h0042);
      chk({15'h0, to}, 16'h0000);
      chk({14'h0, fcs_flash_model_i.lastKind}, 16'(i + 1));
    end
    busyLen = 16'hffff;
    run(3'h1, 16'h0042);
    chk({15'h0, to}, 16'h0001);
    pwrCycle();
    run(3'h0, 16'h0042);
    chk({15'h0, to}, 16'h0000);
    chk(rd, 16'h0042 ^ SCR);
  endtask
  initial begin
    repeat (10) @(negedge clk);
    chk({12'h000, cmdReady, flashCeB_q, flashOeB_q, flashWeB_q}, 16'h000f);
    rst_b = 1'b1;
    @(negedge clk);
    tIdent();
    tErase();
    endSim();
  end
endmodule
